// ===== pkg/io_space_consts.vh
/*
 constants for the controller-wide digital i/o space: point counts,
 range boundaries, drive-mapped input positions and drive type codes.
 assumes inclusion by bare name from the design files.
*/
`ifndef IO_SPACE_CONSTS_VH
`define IO_SPACE_CONSTS_VH
`define IO_POINTS 256
`define IO_ADDR_W 8
`define OUT_ABSENT_LAST 8'h07
`define OUT_PHYS_FIRST 8'h08
`define OUT_PHYS_LAST 8'h0F
`define OUT_SOFT_FIRST 8'h10
`define IN_PHYS_LAST 8'h0F
`define IN_DRV_FIRST 8'h10
`define IN_DRV_LAST 8'h1F
`define IN_FWD_LIMIT 4'h0
`define IN_REV_LIMIT 4'h1
`define IN_HOME_DECEL 4'h2
`define IN_PHASE_A 4'h3
`define IN_PHASE_B 4'h4
`define IN_PHASE_Z 4'h5
`define IN_LATCH_1 4'h6
`define IN_LATCH_2 4'h7
`define IN_LATCH_3 4'h8
`define IN_BRAKE 4'h9
`define IN_ESTOP 4'hA
`define IN_GEN_2 4'hB
`define IN_GP_28 4'hC
`define IN_GP_29 4'hD
`define IN_GP_30 4'hE
`define IN_GP_31 4'hF
`define PIN_FWD_LIMIT 5'h00
`define PIN_REV_LIMIT 5'h01
`define PIN_HOME_DECEL 5'h02
`define PIN_PHASE_A 5'h03
`define PIN_PHASE_B 5'h04
`define PIN_PHASE_Z 5'h05
`define PIN_LATCH_1 5'h06
`define PIN_LATCH_2 5'h07
`define PIN_LATCH_3 5'h08
`define PIN_BRAKE 5'h09
`define PIN_ESTOP 5'h0A
`define PIN_BASEBLOCK 5'h0B
`define PIN_GEN_2 5'h0C
`define PIN_GEN_12 5'h0D
`define PIN_GEN_13 5'h0E
`define PIN_GEN_14 5'h0F
`define PIN_GEN_15 5'h10
`define PIN_TORQUE_POS 5'h11
`define PIN_TORQUE_NEG 5'h12
`define PIN_GEN_0 5'h13
`define PIN_GEN_1 5'h14
`define DRV_TYPE_A 2'h0
`define DRV_TYPE_B 2'h1
`define DRV_TYPE_C 2'h2
`define DRV_TYPE_D 2'h3
`endif

// ===== hdl/drive_input_mapper.v
/*
 registered mapping of one drive's connector inputs onto the sixteen
 drive-mapped input points 16..31 of the controller input space.
 assumes drive signals already synchronised to clock and polarity-corrected
 (active high) by the caller; drive type is stable while used.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_space_consts.vh"
module drive_input_mapper (
   input wire clock,
   input wire rst_n,
   input wire drive_present,
   input wire drive_on_serial_bus,
   input wire [1:0] drive_type,
   input wire [15:0] drive_sig,
   output reg [15:0] mapped_ff
);
   // which drive points have a source for each drive type
   function [15:0] source_mask;
      input [1:0] dtype;
      begin
         case (dtype)
            `DRV_TYPE_A: source_mask = 16'hF3FF; // no e-stop, no general in 2
            `DRV_TYPE_B: source_mask = 16'hF7FF; // base-block present, no gen 2
            `DRV_TYPE_C: source_mask = 16'h0647; // fixed small signal set
            `DRV_TYPE_D: source_mask = 16'hFFE7; // no phase a or b
            default: source_mask = 16'h0000;
         endcase
      end
   endfunction
   reg [15:0] nxt_mapped;
   // mask drive signals; only serial-bus drives are mapped
   always @* begin
      nxt_mapped = 16'h0000;
      if (drive_present && drive_on_serial_bus) begin // RULE_10
         nxt_mapped = drive_sig & source_mask(drive_type); // RULE_16
      end
   end
   // register the mapped points
   always @(posedge clock) begin
      if (!rst_n) begin
         mapped_ff <= 16'h0000;
      end else begin
         mapped_ff <= nxt_mapped; // RULE_11
      end
   end
endmodule // drive_input_mapper
`default_nettype wire

// ===== hdl/digital_io_space_map.v
/*
 controller-wide digital i/o space: 256 output points and 256 input
 points with absent, physical and stored ranges, plus drive input mapping.
 assumes a one-cycle command interface from the embedded program, raw
 front-connector inputs and drive inputs from outside the clock domain.
 drive pins pass a two-flop stage as one group before routing by type.
*/
// Overview of operation
// RULE_01 - one shared i/o space of 256 inputs and 256 outputs, from zero
// RULE_02 - outputs 0..7 store nothing; writes dropped, reads give 0
// RULE_03 - outputs 8..15 drive front lines; reads return driven state
// RULE_04 - outputs 16..255 are stored bits, read back exactly, host-mappable
// RULE_05 - outputs are global, never indexed per axis
// RULE_06 - inputs 0..15 follow energised front lines, read present state
// RULE_07 - inputs 16..255 readable; unmapped they are software-only
// RULE_08 - inputs are global, never indexed per axis
// RULE_09 - general read gives physical inputs only; drive inputs read separately
// RULE_10 - drive inputs mapped only for serial-bus drives, not flexible-axis
// RULE_11 - points 16,17,18 carry forward limit, reverse limit, home decel
// RULE_12 - points 19,20,21 carry encoder phases a,b,z where present
// RULE_13 - points 22,23,24 carry latch inputs 1,2,3 where present
// RULE_14 - points 28..31 carry general inputs or torque limits by drive type
// RULE_15 - 25 brake, 26 e-stop or base-block, 27 general input 2 else 0
// RULE_16 - drive points with no source for the type read 0
`timescale 1ns/1ps
`default_nettype none
`include "io_space_consts.vh"
module digital_io_space_map (
   input wire clock,
   input wire rst_n,
   input wire out_wr,
   input wire [7:0] out_addr,
   input wire out_wdata,
   input wire out_rd,
   output reg out_rdata_ff,
   output reg out_rvalid_ff,
   input wire in_rd,
   input wire [7:0] in_addr,
   output reg in_rdata_ff,
   output reg in_rvalid_ff,
   input wire drv_rd,
   input wire [3:0] drv_addr,
   output reg drv_rdata_ff,
   output reg drv_rvalid_ff,
   input wire host_in_wr,
   input wire [7:0] host_in_addr,
   input wire host_in_wdata,
   input wire [15:0] front_in,
   output reg [7:0] front_out_ff,
   input wire drive_present,
   input wire drive_on_serial_bus,
   input wire [1:0] drive_type,
   input wire forward_limit_in,
   input wire reverse_limit_in,
   input wire home_decel_in,
   input wire encoder_phase_a,
   input wire encoder_phase_b,
   input wire encoder_phase_z,
   input wire latch_in_1,
   input wire latch_in_2,
   input wire latch_in_3,
   input wire brake_out_state,
   input wire emergency_stop_in,
   input wire hard_baseblock_in,
   input wire general_in_2,
   input wire general_in_12,
   input wire general_in_13,
   input wire general_in_14,
   input wire general_in_15,
   input wire torque_limit_pos_in,
   input wire torque_limit_neg_in,
   input wire general_in_0,
   input wire general_in_1
);
   // stored outputs 16..255 and software/host inputs 16..255
   reg [255:0] out_store_ff; // RULE_01
   reg [255:0] in_store_ff;
   // synchroniser stages for front lines and drive pins
   reg [15:0] front_meta_ff;
   reg [15:0] front_sync_ff;
   reg [20:0] pin_meta_ff;
   reg [20:0] pin_sync_ff;
   // drive points ahead of the type mask
   reg [15:0] drv_raw;
   wire [15:0] drv_mapped;
   // address range decode shared by the command paths
   function is_phys_out;
      input [7:0] a;
      begin
         is_phys_out = (a >= `OUT_PHYS_FIRST) && (a <= `OUT_PHYS_LAST);
      end
   endfunction
   function is_stored_out;
      input [7:0] a;
      begin
         is_stored_out = (a >= `OUT_SOFT_FIRST);
      end
   endfunction
   // route synchronised drive pins onto points 16..31 by drive type
   always @* begin
      drv_raw = 16'h0000;
      case (drive_type)
         // type a: full set, no e-stop or general input 2 source, general inputs 12..15 on 28..31
         `DRV_TYPE_A: begin
            drv_raw[`IN_FWD_LIMIT] = pin_sync_ff[`PIN_FWD_LIMIT]; // RULE_11
            drv_raw[`IN_REV_LIMIT] = pin_sync_ff[`PIN_REV_LIMIT];
            drv_raw[`IN_HOME_DECEL] = pin_sync_ff[`PIN_HOME_DECEL];
            drv_raw[`IN_PHASE_A] = pin_sync_ff[`PIN_PHASE_A]; // RULE_12
            drv_raw[`IN_PHASE_B] = pin_sync_ff[`PIN_PHASE_B];
            drv_raw[`IN_PHASE_Z] = pin_sync_ff[`PIN_PHASE_Z];
            drv_raw[`IN_LATCH_1] = pin_sync_ff[`PIN_LATCH_1]; // RULE_13
            drv_raw[`IN_LATCH_2] = pin_sync_ff[`PIN_LATCH_2];
            drv_raw[`IN_LATCH_3] = pin_sync_ff[`PIN_LATCH_3];
            drv_raw[`IN_BRAKE] = pin_sync_ff[`PIN_BRAKE]; // RULE_15
            drv_raw[`IN_ESTOP] = 1'b0; // RULE_16
            drv_raw[`IN_GEN_2] = 1'b0; // RULE_15
            drv_raw[`IN_GP_28] = pin_sync_ff[`PIN_GEN_12]; // RULE_14
            drv_raw[`IN_GP_29] = pin_sync_ff[`PIN_GEN_13];
            drv_raw[`IN_GP_30] = pin_sync_ff[`PIN_GEN_14];
            drv_raw[`IN_GP_31] = pin_sync_ff[`PIN_GEN_15];
         end
         // type b: as type a, with the base-block input on point 26
         `DRV_TYPE_B: begin
            drv_raw[`IN_FWD_LIMIT] = pin_sync_ff[`PIN_FWD_LIMIT]; // RULE_11
            drv_raw[`IN_REV_LIMIT] = pin_sync_ff[`PIN_REV_LIMIT];
            drv_raw[`IN_HOME_DECEL] = pin_sync_ff[`PIN_HOME_DECEL];
            drv_raw[`IN_PHASE_A] = pin_sync_ff[`PIN_PHASE_A]; // RULE_12
            drv_raw[`IN_PHASE_B] = pin_sync_ff[`PIN_PHASE_B];
            drv_raw[`IN_PHASE_Z] = pin_sync_ff[`PIN_PHASE_Z];
            drv_raw[`IN_LATCH_1] = pin_sync_ff[`PIN_LATCH_1]; // RULE_13
            drv_raw[`IN_LATCH_2] = pin_sync_ff[`PIN_LATCH_2];
            drv_raw[`IN_LATCH_3] = pin_sync_ff[`PIN_LATCH_3];
            drv_raw[`IN_BRAKE] = pin_sync_ff[`PIN_BRAKE]; // RULE_15
            drv_raw[`IN_ESTOP] = pin_sync_ff[`PIN_BASEBLOCK]; // RULE_15
            drv_raw[`IN_GEN_2] = 1'b0; // RULE_15
            drv_raw[`IN_GP_28] = pin_sync_ff[`PIN_GEN_12]; // RULE_14
            drv_raw[`IN_GP_29] = pin_sync_ff[`PIN_GEN_13];
            drv_raw[`IN_GP_30] = pin_sync_ff[`PIN_GEN_14];
            drv_raw[`IN_GP_31] = pin_sync_ff[`PIN_GEN_15];
         end
         // type c: small fixed set, everything else reads 0
         `DRV_TYPE_C: begin
            drv_raw[`IN_FWD_LIMIT] = pin_sync_ff[`PIN_FWD_LIMIT]; // RULE_11
            drv_raw[`IN_REV_LIMIT] = pin_sync_ff[`PIN_REV_LIMIT];
            drv_raw[`IN_HOME_DECEL] = pin_sync_ff[`PIN_HOME_DECEL];
            drv_raw[`IN_PHASE_A] = 1'b0; // RULE_16
            drv_raw[`IN_PHASE_B] = 1'b0;
            drv_raw[`IN_PHASE_Z] = 1'b0;
            drv_raw[`IN_LATCH_1] = pin_sync_ff[`PIN_LATCH_1]; // RULE_13
            drv_raw[`IN_LATCH_2] = 1'b0;
            drv_raw[`IN_LATCH_3] = 1'b0;
            drv_raw[`IN_BRAKE] = pin_sync_ff[`PIN_BRAKE]; // RULE_15
            drv_raw[`IN_ESTOP] = pin_sync_ff[`PIN_ESTOP]; // RULE_15
            drv_raw[`IN_GEN_2] = 1'b0;
            drv_raw[`IN_GP_28] = 1'b0; // RULE_16
            drv_raw[`IN_GP_29] = 1'b0;
            drv_raw[`IN_GP_30] = 1'b0;
            drv_raw[`IN_GP_31] = 1'b0;
         end
         // type d: no phase a or b, torque limits and general 0, 1 on 28..31
         `DRV_TYPE_D: begin
            drv_raw[`IN_FWD_LIMIT] = pin_sync_ff[`PIN_FWD_LIMIT]; // RULE_11
            drv_raw[`IN_REV_LIMIT] = pin_sync_ff[`PIN_REV_LIMIT];
            drv_raw[`IN_HOME_DECEL] = pin_sync_ff[`PIN_HOME_DECEL];
            drv_raw[`IN_PHASE_A] = 1'b0; // RULE_12
            drv_raw[`IN_PHASE_B] = 1'b0;
            drv_raw[`IN_PHASE_Z] = pin_sync_ff[`PIN_PHASE_Z];
            drv_raw[`IN_LATCH_1] = pin_sync_ff[`PIN_LATCH_1]; // RULE_13
            drv_raw[`IN_LATCH_2] = pin_sync_ff[`PIN_LATCH_2];
            drv_raw[`IN_LATCH_3] = pin_sync_ff[`PIN_LATCH_3];
            drv_raw[`IN_BRAKE] = pin_sync_ff[`PIN_BRAKE]; // RULE_15
            drv_raw[`IN_ESTOP] = pin_sync_ff[`PIN_ESTOP]; // RULE_15
            drv_raw[`IN_GEN_2] = pin_sync_ff[`PIN_GEN_2]; // RULE_15
            drv_raw[`IN_GP_28] = pin_sync_ff[`PIN_TORQUE_POS]; // RULE_14
            drv_raw[`IN_GP_29] = pin_sync_ff[`PIN_TORQUE_NEG];
            drv_raw[`IN_GP_30] = pin_sync_ff[`PIN_GEN_0];
            drv_raw[`IN_GP_31] = pin_sync_ff[`PIN_GEN_1];
         end
         default: begin
            drv_raw = 16'h0000;
         end
      endcase
   end
   // two-flop synchroniser for the front input lines
   always @(posedge clock) begin
      if (!rst_n) begin
         front_meta_ff <= 16'h0000;
         front_sync_ff <= 16'h0000;
      end else begin
         front_meta_ff <= front_in;
         front_sync_ff <= front_meta_ff; // RULE_06
      end
   end
   // two-flop synchroniser for all drive pins, ahead of any routing logic
   always @(posedge clock) begin
      if (!rst_n) begin
         pin_meta_ff <= 21'h000000;
         pin_sync_ff <= 21'h000000;
      end else begin
         pin_meta_ff <= {
            general_in_1,
            general_in_0,
            torque_limit_neg_in,
            torque_limit_pos_in,
            general_in_15,
            general_in_14,
            general_in_13,
            general_in_12,
            general_in_2,
            hard_baseblock_in,
            emergency_stop_in,
            brake_out_state,
            latch_in_3,
            latch_in_2,
            latch_in_1,
            encoder_phase_z,
            encoder_phase_b,
            encoder_phase_a,
            home_decel_in,
            reverse_limit_in,
            forward_limit_in
         };
         pin_sync_ff <= pin_meta_ff;
      end
   end
   drive_input_mapper u_drive_map (
      .clock(clock),
      .rst_n(rst_n),
      .drive_present(drive_present),
      .drive_on_serial_bus(drive_on_serial_bus),
      .drive_type(drive_type),
      .drive_sig(drv_raw),
      .mapped_ff(drv_mapped)
   );
   // output point writes: absent range dropped, physical and stored kept
   always @(posedge clock) begin
      if (!rst_n) begin
         front_out_ff <= 8'h00;
         out_store_ff <= {256{1'b0}};
      end else if (out_wr) begin // RULE_05
         if (is_phys_out(out_addr)) begin
            front_out_ff[out_addr[2:0]] <= out_wdata; // RULE_03
         end else if (is_stored_out(out_addr)) begin
            out_store_ff[out_addr] <= out_wdata; // RULE_04
         end
      end
   end
   // output point reads, one cycle after the request
   always @(posedge clock) begin
      if (!rst_n) begin
         out_rdata_ff <= 1'b0;
         out_rvalid_ff <= 1'b0;
      end else begin
         out_rvalid_ff <= out_rd;
         if (!out_rd) begin
            out_rdata_ff <= 1'b0;
         end else if (out_addr <= `OUT_ABSENT_LAST) begin
            out_rdata_ff <= 1'b0; // RULE_02
         end else if (is_phys_out(out_addr)) begin
            out_rdata_ff <= front_out_ff[out_addr[2:0]]; // RULE_03
         end else begin
            out_rdata_ff <= out_store_ff[out_addr]; // RULE_04
         end
      end
   end
   // software/host inputs 16..255 written by host memory side
   always @(posedge clock) begin
      if (!rst_n) begin
         in_store_ff <= {256{1'b0}};
      end else if (host_in_wr && (host_in_addr >= `IN_DRV_FIRST)) begin
         in_store_ff[host_in_addr] <= host_in_wdata; // RULE_07
      end
   end
   // general input read: physical front lines and software inputs only
   always @(posedge clock) begin
      if (!rst_n) begin
         in_rdata_ff <= 1'b0;
         in_rvalid_ff <= 1'b0;
      end else begin
         in_rvalid_ff <= in_rd; // RULE_08
         if (!in_rd) begin
            in_rdata_ff <= 1'b0;
         end else if (in_addr <= `IN_PHYS_LAST) begin
            in_rdata_ff <= front_sync_ff[in_addr[3:0]]; // RULE_06
         end else begin
            in_rdata_ff <= in_store_ff[in_addr]; // RULE_09
         end
      end
   end
   // separate drive-input read of points 16..31
   always @(posedge clock) begin
      if (!rst_n) begin
         drv_rdata_ff <= 1'b0;
         drv_rvalid_ff <= 1'b0;
      end else begin
         drv_rvalid_ff <= drv_rd;
         if (drv_rd) begin
            drv_rdata_ff <= drv_mapped[drv_addr]; // RULE_09
         end else begin
            drv_rdata_ff <= 1'b0;
         end
      end
   end
endmodule // digital_io_space_map
`default_nettype wire

// ===== testbench/servo_drive_model.sv
/* behavioural servo drive: presents its connector signal levels.
 assumes the bench sets the wanted levels; they change after an edge. */
`timescale 1ns/1ps
`default_nettype none
module servo_drive_model (
   input wire logic clock,
   input wire logic [20:0] level,
   output logic [20:0] sig
);
   // connector levels, already active high, launched after the edge
   always_ff @(posedge clock) begin
      sig <= level;
   end
endmodule // servo_drive_model
`default_nettype wire

// ===== testbench/io_space_checker_assertions.sv
/* checker on the command ports of the i/o space block.
 assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module io_space_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic out_wr,
   input wire logic [7:0] out_addr,
   input wire logic out_wdata,
   input wire logic out_rd,
   input wire logic out_rdata_ff,
   input wire logic out_rvalid_ff,
   input wire logic in_rd,
   input wire logic in_rvalid_ff,
   input wire logic drv_rd,
   input wire logic drv_rvalid_ff,
   input wire logic [7:0] front_out_ff
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [2:0] a_q;
   logic [7:0] fo_q;
   // address and front state of the previous cycle
   always_ff @(posedge clock) begin
      a_q <= out_addr[2:0];
      fo_q <= front_out_ff;
   end
   property p_rd_ack; out_rd |=> out_rvalid_ff; endproperty
   a_rd_ack: assert property (p_rd_ack) else $error("no output read answer");
   property p_absent; out_rd && out_addr < 8'h08 |=> !out_rdata_ff; endproperty
   a_absent: assert property (p_absent) else $error("absent output read not 0");
   property p_front_wr; out_wr && out_addr[7:3] == 5'h01 |=> front_out_ff[a_q] == $past(out_wdata);
   endproperty
   a_front_wr: assert property (p_front_wr) else $error("front output not written");
   property p_front_rd; out_rd && !out_wr && out_addr[7:3] == 5'h01 |=> out_rdata_ff == fo_q[a_q];
   endproperty
   a_front_rd: assert property (p_front_rd) else $error("front read not driven state");
   property p_soft; out_wr && out_addr > 8'h0F ##1 out_rd && !out_wr && out_addr == $past(out_addr)
      |=> out_rdata_ff == $past(out_wdata, 2); endproperty
   a_soft: assert property (p_soft) else $error("stored output read back wrong");
   property p_idle; !out_rd |=> !out_rvalid_ff && !out_rdata_ff; endproperty
   a_idle: assert property (p_idle) else $error("output answer without read");
   property p_hold; !out_wr |=> $stable(front_out_ff); endproperty
   a_hold: assert property (p_hold) else $error("front output moved");
   property p_in_ack; in_rd |=> in_rvalid_ff; endproperty
   a_in_ack: assert property (p_in_ack) else $error("no input read answer");
   property p_drv_ack; drv_rd |=> drv_rvalid_ff; endproperty
   a_drv_ack: assert property (p_drv_ack) else $error("no drive read answer");
endmodule // io_space_checker
bind digital_io_space_map io_space_checker u_chk (.clock(clock), .rst_n(rst_n), .out_wr(out_wr),
   .out_addr(out_addr), .out_wdata(out_wdata), .out_rd(out_rd), .out_rdata_ff(out_rdata_ff),
   .out_rvalid_ff(out_rvalid_ff), .in_rd(in_rd), .in_rvalid_ff(in_rvalid_ff), .drv_rd(drv_rd),
   .drv_rvalid_ff(drv_rvalid_ff), .front_out_ff(front_out_ff));
`default_nettype wire

// ===== testbench/test_digital_io_space_map.sv
/* self-checking bench for the i/o space block with a drive model.
 assumes the checker is bound and reads answer one cycle after taken. */
`timescale 1ns/1ps
`default_nettype none
module test_digital_io_space_map;
   logic clock = 0, rst_n = 0, out_wr = 0, out_wdata = 0, out_rd = 0, in_rd = 0, drv_rd = 0;
   logic host_in_wr = 0, host_in_wdata = 0, present = 1, serial = 1;
   logic [7:0] out_addr = 0, in_addr = 0, host_in_addr = 0, front_out_ff;
   logic [3:0] drv_addr = 0;
   logic [1:0] drive_type = 0;
   logic [15:0] front_in = 0;
   logic [20:0] lvl = 0, s;
   logic out_rdata_ff, out_rvalid_ff, in_rdata_ff, in_rvalid_ff, drv_rdata_ff, drv_rvalid_ff;
   int n_fail = 0, compares = 0, seed = 32'hb9e70fbc, a, t, om[256], im[256];
   servo_drive_model u_drv (.clock(clock), .level(lvl), .sig(s));
   digital_io_space_map DUT (.clock(clock), .rst_n(rst_n), .out_wr(out_wr), .out_addr(out_addr),
      .out_wdata(out_wdata), .out_rd(out_rd), .out_rdata_ff(out_rdata_ff),
      .out_rvalid_ff(out_rvalid_ff), .in_rd(in_rd), .in_addr(in_addr), .in_rdata_ff(in_rdata_ff),
      .in_rvalid_ff(in_rvalid_ff), .drv_rd(drv_rd), .drv_addr(drv_addr),
      .drv_rdata_ff(drv_rdata_ff), .drv_rvalid_ff(drv_rvalid_ff), .host_in_wr(host_in_wr),
      .host_in_addr(host_in_addr), .host_in_wdata(host_in_wdata), .front_in(front_in),
      .front_out_ff(front_out_ff), .drive_present(present), .drive_on_serial_bus(serial),
      .drive_type(drive_type), .forward_limit_in(s[0]), .reverse_limit_in(s[1]),
      .home_decel_in(s[2]), .encoder_phase_a(s[3]), .encoder_phase_b(s[4]),
      .encoder_phase_z(s[5]), .latch_in_1(s[6]), .latch_in_2(s[7]), .latch_in_3(s[8]),
      .brake_out_state(s[9]), .emergency_stop_in(s[10]), .hard_baseblock_in(s[11]),
      .general_in_2(s[12]), .general_in_12(s[13]), .general_in_13(s[14]),
      .general_in_14(s[15]), .general_in_15(s[16]), .torque_limit_pos_in(s[17]),
      .torque_limit_neg_in(s[18]), .general_in_0(s[19]), .general_in_1(s[20]));
   // free-running clock
   initial forever #10 clock = ~clock;
   // expected drive point k for drive type t, from the model levels
   function automatic logic edrv(input int t, input int k);
      case (k)
         3, 4: return t < 2 ? lvl[k] : 1'b0;
         5, 7, 8: return t != 2 ? lvl[k] : 1'b0;
         10: return t == 0 ? 1'b0 : lvl[t == 1 ? 11 : 10];
         11: return t == 3 ? lvl[12] : 1'b0;
         12, 13, 14, 15: return t == 3 ? lvl[k + 5] : (t == 2 ? 1'b0 : lvl[k + 1]);
         default: return lvl[k];
      endcase
   endfunction
   task chk(input logic v, input logic r, input logic e);
      compares++;
      if (v !== 1'b1 || r !== e) begin
         n_fail++;
         $display("MISMATCH %0t got %b want %b", $time, r, e);
      end
   endtask
   // k 0 output point write, k 1 host input write; strobe held for the next step
   task wr(input int k, input int ad, input logic d);
      @(posedge clock);
      out_wr <= (k == 0);
      host_in_wr <= (k == 1);
      out_addr <= ad[7:0];
      host_in_addr <= ad[7:0];
      out_wdata <= d;
      host_in_wdata <= d;
      if (k == 0 && ad > 7) om[ad] = d;
      if (k == 1 && ad > 15) im[ad] = d;
   endtask
   // k 0 output, 1 general input, 2 drive input read; answer checked a cycle later
   task rd(input int k, input int ad, input logic e);
      @(posedge clock);
      out_wr <= 1'b0;
      host_in_wr <= 1'b0;
      out_rd <= (k == 0);
      in_rd <= (k == 1);
      drv_rd <= (k == 2);
      out_addr <= ad[7:0];
      in_addr <= ad[7:0];
      drv_addr <= ad[3:0];
      @(posedge clock);
      out_rd <= 1'b0;
      in_rd <= 1'b0;
      drv_rd <= 1'b0;
      @(negedge clock);
      chk(k == 0 ? out_rvalid_ff : (k == 1 ? in_rvalid_ff : drv_rvalid_ff),
         k == 0 ? out_rdata_ff : (k == 1 ? in_rdata_ff : drv_rdata_ff), e);
   endtask
   task results;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      for (a = 0; a < 48; a++) begin
         t = a < 8 ? a * 33 % 256 : $random(seed) & 255;
         wr(0, t, $random(seed));
         rd(0, t, om[t][0]);
      end
      for (a = 0; a < 256; a++) rd(0, a, om[a][0]);
      for (a = 8; a < 16; a++) chk(1'b1, front_out_ff[a - 8], om[a][0]);
      @(posedge clock);
      front_in <= $random(seed);
      lvl <= $random(seed);
      for (a = 0; a < 24; a++) wr(1, $random(seed) & 255, $random(seed));
      wr(1, 5, 1'b1);
      for (a = 0; a < 256; a++) rd(1, a, a < 16 ? front_in[a] : im[a][0]);
      for (t = 0; t < 4; t++) begin
         @(posedge clock);
         drive_type <= t[1:0];
         lvl <= $random(seed);
         repeat (6) @(posedge clock);
         for (a = 0; a < 16; a++) rd(2, a, edrv(t, a));
      end
      // first a drive off the serial bus, then a serial-bus slot with no drive
      for (t = 0; t < 2; t++) begin
         @(posedge clock);
         serial <= t[0];
         present <= !t[0];
         repeat (6) @(posedge clock);
         for (a = 0; a < 16; a++) rd(2, a, 1'b0);
      end
      results;
   end
   // watchdog at 10000 cycles, well beyond the expected run of about 1440
   initial begin
      #200000;
      n_fail++;
      results;
   end
endmodule // test_digital_io_space_map
`default_nettype wire
